// File: hw/mtb_pkg.sv
// Package: register map, field positions, reset values and carrier types
package mtb_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] MTB_IDX_MAIN_CTRL = 6'h00;
  localparam logic [5:0] MTB_IDX_TOUCH_STAT = 6'h01;
  localparam logic [5:0] MTB_IDX_INT_STAT = 6'h02;
  localparam logic [5:0] MTB_IDX_INT_CLR = 6'h03;
  localparam logic [5:0] MTB_IDX_INT_EN = 6'h04;
  localparam logic [5:0] MTB_IDX_LIMIT_CFG = 6'h2A;
  localparam logic [5:0] MTB_IDX_PAT_CFG = 6'h2B;
  localparam logic [5:0] MTB_IDX_PAT_SEL = 6'h2D;
  // Reset values
  localparam logic [7:0] MTB_RST_LIMIT_CFG = 8'h80;
  localparam logic [7:0] MTB_RST_PAT_CFG = 8'h00;
  localparam logic [7:0] MTB_RST_PAT_SEL = 8'h07;
  localparam logic [1:0] MTB_RST_INT_EN = 2'h3;
  // Field positions
  localparam int MTB_BIT_BLK_EN = 7;
  localparam int MTB_BIT_LIMIT_LO = 2;
  localparam int MTB_BIT_PAT_EN = 7;
  localparam int MTB_BIT_PTH_LO = 2;
  localparam int MTB_BIT_CMP_MODE = 1;
  localparam int MTB_BIT_ALERT_EN = 0;
  localparam int MTB_BIT_MAIN_INT = 0;
  localparam int MTB_BIT_ST_MULTI = 0;
  localparam int MTB_BIT_ST_PAT = 1;
  // AXI responses
  localparam logic [1:0] MTB_RESP_OKAY = 2'h0;
  localparam logic [1:0] MTB_RESP_SLVERR = 2'h2;

  // Results of one polling cycle from the measurement front end
  typedef struct packed {
    logic [2:0][7:0] delta;
    logic [2:0][6:0] touch_th;
    logic [6:0] stby_th;
    logic standby;
    logic [2:0] noise;
  } mtb_fe_t;

  typedef struct packed {
    logic [7:0] limit_cfg;
    logic [7:0] pat_cfg;
    logic [7:0] pat_sel;
    logic [1:0] int_en;
    logic multi_flag;
    logic pat_flag;
    logic main_int;
    logic pat_active;
    logic [2:0] valid;
    logic [2:0] report;
    logic [5:0] aw_idx;
    logic aw_got;
    logic [7:0] wdata;
    logic wlane;
    logic w_got;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } mtb_state_t;
endpackage : mtb_pkg

// File: hw/mtb_top.sv
// Multi-touch blocking and pattern detection with AXI4-Lite registers
// Summary of operation
// RQ1: With blocking disabled every detected touch is reported, none blocked.
// RQ2: With blocking enabled report up to the limit, keep them, block others.
// RQ3: After a reported pad releases, pick touches scanning input 1 to 3.
// RQ4: Limit field 00 means one, 01 two, 10 and 11 three touches.
// RQ5: Touches beyond the limit are blocked and the multi-touch flag set.
// RQ6: Pattern detection runs only when its enable bit is set; off at reset.
// RQ7: Pattern threshold is a fraction of the active or standby threshold.
// RQ8: Threshold select gives 12.5, 25, 37.5 or 100 percent.
// RQ9: Compare mode set: every selected input qualifies gives a pattern event.
// RQ10: Count mode: event when qualifying count reaches the selected count.
// RQ11: Criteria use a single polling cycle, nothing accumulated.
// RQ12: A pattern event blocks all touch reports and raises an interrupt.
// RQ13: Inputs stay blocked while the pattern condition holds, then resume.
// RQ14: Pattern flag clears only on main interrupt clear, condition ended.
// RQ15: Alert enable gates the alert pin; pattern flag sets regardless.
// RQ16: Select bits 2,1,0 choose inputs 3,2,1; register resets to 07h.
// RQ17: Limit configuration resets to 80h: blocking on, limit one.
// RQ18: Alert pin is active low, held until main interrupt bit is cleared.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module mtb_top (
  input wire logic aclk, // 200 MHz clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic eval_strobe, // One pulse per polling cycle result
  input wire mtb_pkg::mtb_fe_t fe, // Front end results for this cycle
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  output logic [2:0] touch_report, // Reported touches, input 1 in bit 0
  output logic irq, // Level interrupt from enabled status
  output logic alert_n // Alert pin, active low
);
  import mtb_pkg::*;

  mtb_state_t st_reg;
  mtb_state_t st_next;

  function automatic logic [1:0] pop3(input logic [2:0] v);
    pop3 = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
  endfunction : pop3

  logic [2:0] raw;
  logic [2:0] qual;
  logic [1:0] limit_n;
  logic pcond;
  logic [2:0] sel;
  logic released;
  logic [2:0] pick;
  logic [7:0] base [3];
  logic [7:0] pth [3];
  logic aw_hit;
  logic w_hit;
  logic do_write;
  logic main_wr;
  logic [5:0] ar_idx;
  logic [7:0] rd_val;
  logic rd_ok;
  logic wr_ok;

  assign sel = st_reg.pat_sel[2:0]; // RQ16

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      base[i] = fe.standby ? {1'b0, fe.stby_th}
                           : {1'b0, fe.touch_th[i]}; // RQ7
      case (st_reg.pat_cfg[MTB_BIT_PTH_LO +: 2]) // RQ8
        2'h0: pth[i] = base[i] >> 3;
        2'h1: pth[i] = base[i] >> 2;
        2'h2: pth[i] = 8'((base[i] >> 2) + (base[i] >> 3));
        default: pth[i] = base[i];
      endcase
      raw[i] = fe.delta[i] > base[i];
      qual[i] = (fe.delta[i] > pth[i]) || fe.noise[i];
    end
  end

  // Limit decode: 10 and 11 both allow three
  always_comb begin
    case (st_reg.limit_cfg[MTB_BIT_LIMIT_LO +: 2]) // RQ4
      2'h0: limit_n = 2'h1;
      2'h1: limit_n = 2'h2;
      default: limit_n = 2'h3;
    endcase
  end

  // Judged on this polling cycle alone
  always_comb begin
    if (!st_reg.pat_cfg[MTB_BIT_PAT_EN]) begin
      pcond = 1'b0; // RQ6
    end else if (st_reg.pat_cfg[MTB_BIT_CMP_MODE]) begin
      pcond = (sel & ~qual) == 3'h0; // RQ9 RQ11
    end else begin
      pcond = pop3(qual) >= pop3(sel); // RQ10 RQ11
    end
  end

  // Keep valid inputs while none has released, then fill in input order up to the limit
  always_comb begin
    logic [1:0] n;
    n = 2'h0;
    // A lowered limit also forces a fresh scan
    released = (st_reg.valid & ~raw) != 3'h0 ||
               pop3(st_reg.valid) > limit_n;
    pick = released ? 3'h0 : (st_reg.valid & raw); // RQ2 RQ3
    n = pop3(pick);
    for (int i = 0; i < 3; i++) begin
      if (raw[i] && !pick[i] && n < limit_n) begin // RQ3
        pick[i] = 1'b1;
        n = 2'(n + 2'h1);
      end
    end
  end

  assign aw_hit = s_axi_awvalid && s_axi_awready;
  assign w_hit = s_axi_wvalid && s_axi_wready;
  assign do_write = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
  assign main_wr = do_write && st_reg.wlane &&
                   st_reg.aw_idx == MTB_IDX_MAIN_CTRL;
  assign ar_idx = s_axi_araddr[7:2];

  always_comb begin
    rd_ok = 1'b1;
    rd_val = 8'h00;
    case (ar_idx)
      MTB_IDX_MAIN_CTRL: rd_val = {7'h00, st_reg.main_int};
      MTB_IDX_TOUCH_STAT: rd_val = {4'h0, st_reg.pat_active, st_reg.report};
      MTB_IDX_INT_STAT: rd_val = {6'h00, st_reg.pat_flag, st_reg.multi_flag};
      MTB_IDX_INT_CLR: rd_val = 8'h00;
      MTB_IDX_INT_EN: rd_val = {6'h00, st_reg.int_en};
      MTB_IDX_LIMIT_CFG: rd_val = st_reg.limit_cfg;
      MTB_IDX_PAT_CFG: rd_val = st_reg.pat_cfg;
      MTB_IDX_PAT_SEL: rd_val = st_reg.pat_sel;
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    case (st_reg.aw_idx)
      MTB_IDX_MAIN_CTRL, MTB_IDX_TOUCH_STAT, MTB_IDX_INT_STAT,
      MTB_IDX_INT_CLR, MTB_IDX_INT_EN, MTB_IDX_LIMIT_CFG,
      MTB_IDX_PAT_CFG, MTB_IDX_PAT_SEL: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    // Write channels taken in either order
    if (aw_hit) begin
      st_next.aw_idx = s_axi_awaddr[7:2];
      st_next.aw_got = 1'b1;
    end
    if (w_hit) begin
      st_next.wdata = s_axi_wdata[7:0];
      st_next.wlane = s_axi_wstrb[0];
      st_next.w_got = 1'b1;
    end
    if (do_write) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = wr_ok ? MTB_RESP_OKAY : MTB_RESP_SLVERR;
      if (st_reg.wlane) begin
        case (st_reg.aw_idx)
          MTB_IDX_LIMIT_CFG: st_next.limit_cfg = st_reg.wdata & 8'h8C;
          MTB_IDX_PAT_CFG: st_next.pat_cfg = st_reg.wdata & 8'h8F;
          MTB_IDX_PAT_SEL: st_next.pat_sel = st_reg.wdata & 8'h07;
          MTB_IDX_INT_EN: st_next.int_en = st_reg.wdata[1:0];
          MTB_IDX_INT_CLR: begin
            if (st_reg.wdata[MTB_BIT_ST_MULTI]) begin
              st_next.multi_flag = 1'b0;
            end
          end
          MTB_IDX_MAIN_CTRL: begin
            if (!st_reg.wdata[MTB_BIT_MAIN_INT]) begin
              st_next.main_int = 1'b0; // RQ18
              if (!st_reg.pat_active) begin
                st_next.pat_flag = 1'b0; // RQ14
              end
            end
          end
          default: ;
        endcase
      end
    end else if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_val;
      st_next.rresp = rd_ok ? MTB_RESP_OKAY : MTB_RESP_SLVERR;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    // Touch evaluation once per polling cycle; events win over clears
    if (eval_strobe) begin
      st_next.pat_active = pcond; // RQ13
      if (pcond) begin
        st_next.report = 3'h0; // RQ12
        st_next.valid = 3'h0;
        st_next.pat_flag = 1'b1; // RQ15
        if (st_reg.pat_cfg[MTB_BIT_ALERT_EN]) begin
          st_next.main_int = 1'b1; // RQ15 RQ18
        end
      end else if (!st_reg.limit_cfg[MTB_BIT_BLK_EN]) begin
        st_next.report = raw; // RQ1
        st_next.valid = raw;
      end else begin
        st_next.report = pick; // RQ2
        st_next.valid = pick;
        if (pop3(raw) > limit_n) begin
          st_next.multi_flag = 1'b1; // RQ5
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.limit_cfg <= MTB_RST_LIMIT_CFG; // RQ17
      st_reg.pat_cfg <= MTB_RST_PAT_CFG; // RQ6
      st_reg.pat_sel <= MTB_RST_PAT_SEL; // RQ16
      st_reg.int_en <= MTB_RST_INT_EN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = {24'h000000, st_reg.rdata};
  assign touch_report = st_reg.report;
  assign irq = |({st_reg.pat_flag, st_reg.multi_flag} & st_reg.int_en);
  assign alert_n = !st_reg.main_int; // RQ18

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic blk_en;
  assign blk_en = st_reg.limit_cfg[MTB_BIT_BLK_EN];

  AST_NO_BLOCK: assert property ( // RQ1
    eval_strobe && !blk_en && !pcond |=> touch_report == $past(raw))
    else $error("touches blocked while blocking disabled");
  AST_LIMIT: assert property ( // RQ2
    eval_strobe && blk_en |=> pop3(touch_report) <= $past(limit_n))
    else $error("more touches reported than the limit");
  AST_SCAN_FIRST: assert property ( // RQ3
    eval_strobe && blk_en && !pcond && released && raw[0] |=>
    touch_report[0])
    else $error("input 1 not chosen first after release");
  AST_LIMIT_DECODE: assert property ( // RQ4
    st_reg.limit_cfg[3:2] == 2'h0 |-> limit_n == 2'h1)
    else $error("limit field 00 not decoded to one");
  AST_MULTI: assert property ( // RQ5
    eval_strobe && blk_en && !pcond && pop3(raw) > limit_n |=>
    st_reg.multi_flag && irq == st_reg.int_en[0] || st_reg.pat_flag)
    else $error("multi touch flag not set");
  AST_PAT_OFF: assert property ( // RQ6
    eval_strobe && !st_reg.pat_cfg[MTB_BIT_PAT_EN] && !st_reg.pat_flag
    |=> !st_reg.pat_flag)
    else $error("pattern flag set while detection disabled");
  AST_PAT_BLOCK: assert property ( // RQ12
    eval_strobe && pcond |=> touch_report == 3'h0 && st_reg.pat_flag)
    else $error("pattern event did not block touches");
  AST_PAT_RESUME: assert property ( // RQ13
    eval_strobe && !pcond && !blk_en |=> !st_reg.pat_active)
    else $error("blocking held after pattern condition ended");
  AST_PAT_HOLD: assert property ( // RQ14
    st_reg.pat_flag && !(main_wr && !st_reg.wdata[0]) |=> st_reg.pat_flag)
    else $error("pattern flag lost without host clear");
  AST_ALERT_GATE: assert property ( // RQ15
    eval_strobe && pcond && !st_reg.pat_cfg[0] && alert_n |=> alert_n)
    else $error("alert asserted with alert disabled");
  AST_ALERT_ON: assert property ( // RQ18
    eval_strobe && pcond && st_reg.pat_cfg[0] |=> !alert_n [*2])
    else $error("alert not asserted and held");

  // Blocking and limit checks
  AST_MULTI_OFF: assert property ( // RQ1
    eval_strobe && !blk_en && !st_reg.multi_flag |=> !st_reg.multi_flag)
    else $error("multi touch flag set while blocking disabled");
  AST_KEEP_VALID: assert property ( // RQ2
    eval_strobe && blk_en && !pcond && !released |=>
    (touch_report & $past(st_reg.valid)) == $past(st_reg.valid))
    else $error("a held touch lost its report");
  AST_ONLY_TOUCHED: assert property ( // RQ2 RQ5
    eval_strobe && blk_en |=> (touch_report & ~$past(raw)) == 3'h0)
    else $error("untouched input reported");
  AST_SCAN_FILL: assert property ( // RQ3
    eval_strobe && blk_en && !pcond && released && pop3(raw) >= limit_n
    |=> pop3(touch_report) == $past(limit_n))
    else $error("rescan did not fill up to the limit");
  AST_LIMIT_TWO: assert property ( // RQ4
    st_reg.limit_cfg[3:2] == 2'h1 |-> limit_n == 2'h2)
    else $error("limit field 01 not decoded to two");
  AST_LIMIT_THREE: assert property ( // RQ4
    st_reg.limit_cfg[3] |-> limit_n == 2'h3)
    else $error("limit field 1x not decoded to three");
  AST_MULTI_STICKY: assert property ( // RQ5
    st_reg.multi_flag && !(do_write && st_reg.wlane && st_reg.wdata[0] &&
    st_reg.aw_idx == MTB_IDX_INT_CLR) |=> st_reg.multi_flag)
    else $error("multi touch flag lost without host clear");

  // Pattern checks
  AST_PAT_EN_OFF: assert property ( // RQ6
    eval_strobe && !st_reg.pat_cfg[MTB_BIT_PAT_EN] |=> !st_reg.pat_active)
    else $error("pattern condition seen while detection disabled");
  AST_PTH_BOUND: assert property ( // RQ7 RQ8
    pth[0] <= base[0] && pth[1] <= base[1] && pth[2] <= base[2])
    else $error("pattern threshold above the base threshold");
  AST_PTH_FULL: assert property ( // RQ8
    st_reg.pat_cfg[3:2] == 2'h3 |-> pth[0] == base[0])
    else $error("full setting not equal to base threshold");
  AST_CMP_MISS: assert property ( // RQ9
    eval_strobe && st_reg.pat_cfg[1] && (sel & ~qual) != 3'h0 |=>
    !st_reg.pat_active)
    else $error("pattern event without every selected input");
  AST_CNT_MISS: assert property ( // RQ10 RQ11
    eval_strobe && !st_reg.pat_cfg[1] && pop3(qual) < pop3(sel) |=>
    !st_reg.pat_active)
    else $error("count event with too few qualifying inputs");
  AST_PAT_IRQ: assert property ( // RQ12
    eval_strobe && pcond && st_reg.int_en[1] |=> irq || !st_reg.int_en[1])
    else $error("pattern event raised no interrupt");
  AST_PAT_QUIET: assert property ( // RQ13
    st_reg.pat_active |-> touch_report == 3'h0)
    else $error("touch reported while pattern condition holds");
  AST_PAT_CLEAR: assert property ( // RQ14
    main_wr && !st_reg.wdata[0] && !st_reg.pat_active &&
    !(eval_strobe && pcond) |=> !st_reg.pat_flag)
    else $error("pattern flag not cleared by host");
  AST_SEL_MASK: assert property ( // RQ16
    st_reg.pat_sel[7:3] == 5'h00)
    else $error("unused pattern select bits set");
  AST_ALERT_HOLD: assert property ( // RQ18
    !alert_n && !(main_wr && !st_reg.wdata[0]) |=> !alert_n)
    else $error("alert released without host clear");

  // First edge after reset
  AST_RESET_CFG: assert property ( // RQ17
    !$past(aresetn) |-> st_reg.limit_cfg == MTB_RST_LIMIT_CFG)
    else $error("limit configuration not at reset value");

  // Main scenarios
  COV_MULTI: cover property (eval_strobe && blk_en && pop3(raw) > limit_n);
  COV_PAT_CMP: cover property (eval_strobe && pcond && st_reg.pat_cfg[1]);
  COV_PAT_CNT: cover property (eval_strobe && pcond && !st_reg.pat_cfg[1]);
  COV_RELEASE: cover property (eval_strobe && blk_en && released ##1
    touch_report != 3'h0);
  COV_PAT_CLEAR: cover property (main_wr && !st_reg.wdata[0] &&
    st_reg.pat_flag && !st_reg.pat_active);
endmodule : mtb_top

// File: testbench/mtb_fe_model.sv
// Front end model: presents one polling result per request
`timescale 1ns/1ps
module mtb_fe_model (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic go, // Request to present one result
  input wire mtb_pkg::mtb_fe_t val, // Result to present
  output logic eval_strobe, // One-cycle result strobe
  output mtb_pkg::mtb_fe_t fe // Result, scrambled outside the strobe
);
  import mtb_pkg::*;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eval_strobe <= 1'b0;
      fe <= '0;
    end else if (go) begin
      eval_strobe <= 1'b1;
      fe <= val;
    end else begin
      eval_strobe <= 1'b0;
      // Stale results change every cycle so late sampling shows up
      fe <= ~fe;
    end
  end
endmodule : mtb_fe_model

// File: testbench/mtb_top_test.sv
// Testbench for the multi-touch blocking and pattern block
`timescale 1ns/1ps
module mtb_top_test;
  import mtb_pkg::*;
  logic aclk = 0, aresetn = 0, go = 0, evs, awv = 0, wv = 0, bready = 0;
  logic arv = 0, rready = 0, awr, wr, bv, arr, rv, irq, alert_n;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d;
  logic [1:0] bresp, rresp, rs, en = 2'h3;
  logic [2:0] rep, prev = 0, ps = 3'h7;
  logic [7:0] lc = 8'h80, pc = 8'h00;
  logic [3:0] ws = 4'hF;
  logic mf = 0, pf = 0, mi = 0, cond = 0;
  mtb_fe_t val = '0, fe;
  int n_mismatch = 0, compares = 0, seed = 32'h5a8e;
  logic [5:0] ri [5] = '{MTB_IDX_LIMIT_CFG, MTB_IDX_PAT_CFG, MTB_IDX_PAT_SEL,
    MTB_IDX_INT_EN, 6'h3F};
  logic [31:0] rx [5] = '{32'h80, 32'h00, 32'h07, 32'h03, 32'h00};
  mtb_fe_model fem_u (.aclk(aclk), .aresetn(aresetn), .go(go), .val(val),
    .eval_strobe(evs), .fe(fe));
  mtb_top dut_u (.aclk(aclk), .aresetn(aresetn), .eval_strobe(evs), .fe(fe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .touch_report(rep),
    .irq(irq), .alert_n(alert_n));
  initial forever #2.5 aclk = ~aclk;
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input int k);
    if (k >= 50) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : tmo
  task automatic wr_reg(input logic [5:0] i, input logic [7:0] v);
    int k;
    @(posedge aclk);
    awaddr <= {24'h0, i, 2'b00};
    wdata <= {24'h0, v};
    awv <= 1;
    wv <= 1;
    bready <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
      if (bv) break;
    end
    tmo(k);
    bready <= 0;
    rs = bresp;
  endtask : wr_reg
  task automatic rd_reg(input logic [5:0] i);
    int k;
    @(posedge aclk);
    araddr <= {24'h0, i, 2'b00};
    arv <= 1;
    rready <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arv && arr) arv <= 0;
      if (rv) break;
    end
    tmo(k);
    rready <= 0;
    d = rdata;
    rs = rresp;
  endtask : rd_reg
  function automatic int lim_of(input logic [1:0] f);
    return (f == 2'h0) ? 1 : (f == 2'h1) ? 2 : 3;
  endfunction : lim_of
  // Inputs above base threshold (frac=0) or above pattern threshold or noisy
  function automatic logic [2:0] qual(input mtb_fe_t v, input logic frac);
    logic [7:0] b, t;
    for (int j = 0; j < 3; j++) begin
      b = v.standby ? {1'b0, v.stby_th} : {1'b0, v.touch_th[j]};
      t = !frac ? b : (pc[3:2] == 2'h0) ? b >> 3 : (pc[3:2] == 2'h1) ? b >> 2
        : (pc[3:2] == 2'h2) ? (b >> 2) + (b >> 3) : b;
      qual[j] = (v.delta[j] > t) || (frac && v.noise[j]);
    end
  endfunction : qual
  function automatic logic [2:0] blk(input logic [2:0] raw);
    logic [2:0] r;
    // A lowered limit forces a fresh scan as well
    r = ((prev & raw) == prev && $countones(prev) <= lim_of(lc[3:2])) ?
      prev : 3'h0;
    for (int j = 0; j < 3; j++)
      if (raw[j] && !r[j] && $countones(r) < lim_of(lc[3:2])) r[j] = 1'b1;
    return lc[7] ? r : raw;
  endfunction : blk
  task automatic chk_st;
    rd_reg(MTB_IDX_INT_STAT);
    chk(d, {30'h0, pf, mf});
    chk(32'(irq), 32'(|({pf, mf} & en)));
    chk(32'(alert_n), 32'(!mi));
  endtask : chk_st
  task automatic eval(input logic z);
    logic [63:0] r;
    logic [2:0] raw, q, e;
    logic ev;
    mtb_fe_t v;
    r = {$random(seed), $random(seed)};
    v = z ? '0 : r[55:0];
    @(posedge aclk);
    val <= v;
    go <= 1;
    @(posedge aclk);
    go <= 0;
    repeat (2) @(posedge aclk);
    raw = qual(v, 1'b0);
    q = qual(v, 1'b1);
    ev = pc[7] && (pc[1] ? ((q & ps) == ps) : $countones(q) >= $countones(ps));
    e = ev ? 3'h0 : blk(raw);
    chk(32'(rep), 32'(e));
    rd_reg(MTB_IDX_TOUCH_STAT);
    chk(d, {28'h0, ev, e});
    prev = e;
    mf |= !ev && lc[7] && $countones(raw) > lim_of(lc[3:2]);
    pf |= ev;
    mi |= ev && pc[0];
    cond = ev;
    chk_st();
  endtask : eval
  task automatic clr_main;
    wr_reg(MTB_IDX_MAIN_CTRL, 8'h00);
    mi = 0;
    if (!cond) pf = 0;
    chk_st();
  endtask : clr_main
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    foreach (ri[j]) begin
      rd_reg(ri[j]);
      chk(d, rx[j]);
      chk(32'(rs), 32'((j == 4) ? MTB_RESP_SLVERR : MTB_RESP_OKAY));
    end
    wr_reg(6'h3F, 8'hFF);
    chk(32'(rs), 32'(MTB_RESP_SLVERR));
    ws <= 4'h0;
    wr_reg(MTB_IDX_LIMIT_CFG, 8'h00);
    chk(32'(rs), 32'(MTB_RESP_OKAY));
    ws <= 4'hF;
    rd_reg(MTB_IDX_LIMIT_CFG);
    chk(d, 32'(MTB_RST_LIMIT_CFG));
    $display("test reset values done");
    for (int c = 0; c < 8; c++) begin
      lc = {c[2], 3'h0, c[1:0], 2'h0};
      wr_reg(MTB_IDX_LIMIT_CFG, lc);
      wr_reg(MTB_IDX_INT_CLR, 8'h01);
      mf = 0;
      eval(1'b1);
      repeat (12) eval(1'b0);
    end
    $display("test blocking done");
    lc = 8'h00;
    wr_reg(MTB_IDX_LIMIT_CFG, lc);
    wr_reg(MTB_IDX_INT_CLR, 8'h01);
    mf = 0;
    for (int c = 0; c < 16; c++) begin
      pc = {1'b1, 3'h0, c[1:0], c[2], c[3]};
      ps = 3'($random(seed));
      en = 2'($random(seed));
      wr_reg(MTB_IDX_INT_EN, {6'h0, en});
      wr_reg(MTB_IDX_PAT_CFG, pc);
      wr_reg(MTB_IDX_PAT_SEL, {5'h0, ps});
      repeat (10) eval(1'b0);
      clr_main();
      eval(1'b1);
      clr_main();
    end
    $display("test pattern done");
    report_and_stop();
  end
endmodule : mtb_top_test
